// [bench/reset_source_supply_monitor_tb.sv]
`timescale 1ns/1ps
module reset_source_supply_monitor_tb;
  import rssm_pkg::*;
  localparam int POR = 8;
  localparam logic [11:0] MC = RSSM_ADDR_MONITOR_CTRL;
  localparam logic [11:0] RC = RSSM_ADDR_RESET_CAUSE;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] o_prdata, rdat;
  logic        o_pready, o_pslverr, perr, supply_above, rst_pin_n, o_rst_pin_out, o_rst_pin_oe;
  logic        o_core_hold, o_sfr_load_defaults, o_irq_timers_disable, o_stack_ptr_reinit, o_data_mem_clear;
  logic        o_port_open_drain, o_weak_pullup_en, o_wdog_enable, o_monitor_power, o_irq;
  logic [7:0]  o_port_latch;
  logic [15:0] o_pc_load;
  logic [1:0]  o_clk_select;
  logic [3:0]  o_wdog_divide;
  logic        supply = 1'b0;
  logic        pull = 1'b0;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  rssm_reset_sequencer #(.POR_DELAY_CYCLES(POR)) rssm_reset_sequencer_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_supply_above(supply_above), .i_rst_pin_n(rst_pin_n), .o_rst_pin_out(o_rst_pin_out),
    .o_rst_pin_oe(o_rst_pin_oe), .o_core_hold(o_core_hold), .o_sfr_load_defaults(o_sfr_load_defaults),
    .o_irq_timers_disable(o_irq_timers_disable), .o_stack_ptr_reinit(o_stack_ptr_reinit),
    .o_data_mem_clear(o_data_mem_clear), .o_port_latch(o_port_latch), .o_port_open_drain(o_port_open_drain),
    .o_weak_pullup_en(o_weak_pullup_en), .o_pc_load(o_pc_load), .o_clk_select(o_clk_select),
    .o_wdog_enable(o_wdog_enable), .o_wdog_divide(o_wdog_divide), .o_monitor_power(o_monitor_power),
    .o_irq(o_irq));

  rssm_supply_pin_model rssm_supply_pin_model_i (
    .i_supply_ok(supply), .i_ext_pull_low(pull), .i_pin_out(o_rst_pin_out), .i_pin_oe(o_rst_pin_oe),
    .o_supply_above(supply_above), .o_rst_pin_n(rst_pin_n));

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error land in rdat and perr.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (o_pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = o_prdata;
    perr = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits a bounded number of edges for the core hold to reach a level.
  task automatic hw(input logic want, input int max);
    int n;
    n = 0;
    while (o_core_hold !== want && n < max) begin
      n++;
      @(posedge clk);
    end
  endtask : hw

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({o_core_hold, o_rst_pin_oe}, 2'b11);
    chk({o_port_latch, o_port_open_drain, o_weak_pullup_en}, {RSSM_PORT_LATCH_RESET, 2'b11});
    chk({o_sfr_load_defaults, o_irq_timers_disable, o_stack_ptr_reinit, o_data_mem_clear}, 4'hE);
    supply <= 1'b1;
    repeat (POR) @(posedge clk);
    chk(o_core_hold, 1'b1);
    hw(1'b0, 4);
    chk({o_core_hold, o_rst_pin_oe}, 2'b00);
    chk({o_pc_load, o_clk_select, o_wdog_divide}, {RSSM_PC_RESET, RSSM_CLKSEL_INTERNAL, RSSM_WDOG_DIVIDE});
    apb(1'b0, RC, '0);
    chk(rdat, 32'h2);
    apb(1'b0, MC, '0);
    chk(rdat, 32'hC0);
    $display("[TEST] power-up done");
    apb(1'b1, MC, 32'h3F);
    apb(1'b0, MC, '0);
    chk(rdat, 32'h40);
    supply <= 1'b0;
    repeat (4) @(posedge clk);
    chk(o_core_hold, 1'b0);
    apb(1'b0, MC, '0);
    chk(rdat, 32'h0);
    supply <= 1'b1;
    apb(1'b1, MC, 32'h80);
    @(posedge clk);
    chk(o_monitor_power, 1'b1);
    apb(1'b1, RC, 32'h2);
    apb(1'b1, RSSM_ADDR_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    chk(o_irq, 1'b0);
    supply <= 1'b0;
    hw(1'b1, 4);
    chk({o_core_hold, o_rst_pin_oe, o_wdog_enable}, 3'b111);
    repeat (2) @(posedge clk);
    chk(o_irq, 1'b1);
    supply <= 1'b1;
    hw(1'b0, 3);
    chk(o_core_hold, 1'b0);
    apb(1'b0, RC, '0);
    chk(rdat, 32'h2);
    apb(1'b0, RSSM_ADDR_IRQ_STATUS, '0);
    chk(rdat, 32'h3);
    apb(1'b1, RSSM_ADDR_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge clk);
    chk(o_irq, 1'b0);
    $display("[TEST] monitor reset done");
    apb(1'b1, MC, 32'h0);
    pull <= 1'b1;
    hw(1'b1, 4);
    chk({o_core_hold, o_rst_pin_oe}, 2'b10);
    pull <= 1'b0;
    hw(1'b0, 4);
    apb(1'b0, RC, '0);
    chk(rdat, 32'h1);
    apb(1'b0, MC, '0);
    chk(rdat, 32'h40);
    repeat (10) @(posedge clk);
    apb(1'b0, RC, '0);
    chk(rdat, 32'h1);
    apb(1'b0, 12'h400, 32'h0);
    chk({perr, rdat}, {1'b1, 32'h0});
    $display("[TEST] pin reset done");
    results();
  end
endmodule : reset_source_supply_monitor_tb

// [bench/rssm_supply_pin_model.sv]
`timescale 1ns/1ps
// Far side: the supply comparator and the reset pin with its external pull-up.
module rssm_supply_pin_model (
  // Commands from the bench.
  input  wire logic i_supply_ok,
  input  wire logic i_ext_pull_low,
  // Pin driver of the device.
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  // Levels seen by the device.
  output logic      o_supply_above,
  output logic      o_rst_pin_n
);
  // The comparator output follows the supply level.
  assign o_supply_above = i_supply_ok;
  // Wired pin: either party may pull it low, otherwise the pull-up wins.
  assign o_rst_pin_n = (i_ext_pull_low || (i_pin_oe && !i_pin_out)) ? 1'b0 : 1'b1;
endmodule : rssm_supply_pin_model

// [design/rssm_pkg.sv]
package rssm_pkg;

  // Register byte addresses on the APB side (printed offsets are not all multiples of four).
  localparam logic [7:0]  RSSM_IDX_MONITOR_CTRL = 8'hFF;
  localparam logic [7:0]  RSSM_IDX_RESET_CAUSE  = 8'hEF;
  localparam logic [11:0] RSSM_ADDR_MONITOR_CTRL = {2'h0, RSSM_IDX_MONITOR_CTRL, 2'h0};
  localparam logic [11:0] RSSM_ADDR_RESET_CAUSE  = {2'h0, RSSM_IDX_RESET_CAUSE, 2'h0};
  localparam logic [11:0] RSSM_ADDR_IRQ_STATUS   = 12'h800;
  localparam logic [11:0] RSSM_ADDR_IRQ_ENABLE   = 12'h804;
  localparam logic [11:0] RSSM_ADDR_IRQ_CLEAR    = 12'h808;

  // Field positions.
  localparam int RSSM_BIT_MON_ENABLE = 7;
  localparam int RSSM_BIT_MON_STATUS = 6;
  localparam int RSSM_BIT_POWER_ON   = 1;
  localparam int RSSM_BIT_PIN_RESET  = 0;
  localparam int RSSM_IRQ_BIT_SUPPLY_LOW = 0;
  localparam int RSSM_IRQ_BIT_RESET_EXIT = 1;

  // Values after reset and on exit.
  localparam logic [7:0]  RSSM_PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] RSSM_PC_RESET         = 16'h0000;
  localparam logic [3:0]  RSSM_WDOG_DIVIDE      = 4'hC;
  localparam logic [1:0]  RSSM_CLKSEL_INTERNAL  = 2'h0;

  // Power-on release delay: 0.3 ms at a 40 ns clock, longest time rounds down.
  localparam int RSSM_CLK_PERIOD_PS    = 40000;
  localparam int RSSM_POR_DELAY_US     = 300;
  localparam int RSSM_POR_DELAY_CYCLES = (RSSM_POR_DELAY_US * 1000000) / RSSM_CLK_PERIOD_PS;

  // Sequencer states.
  typedef enum logic [1:0] {
    RSSM_ST_POWER_UP = 2'b00,
    RSSM_ST_POR_WAIT = 2'b01,
    RSSM_ST_IN_RESET = 2'b10,
    RSSM_ST_RUN      = 2'b11
  } rssm_state_e;

endpackage : rssm_pkg

// [design/rssm_reset_sequencer.sv]
`timescale 1ns/1ps

// Summary of operation
// - In reset, halt core, load register defaults, force ports, disable interrupts and timers.
// - Data memory is never cleared; only the stack pointer is reinitialised.
// - Port latches read 0xFF and weak pullups on during and after reset; open-drain only during reset.
// - Power-on and monitor resets drive the reset pin low throughout reset.
// - On exit clear program counter, select internal oscillator, fetch from zero.
// - While in reset the watchdog is enabled, clocked at system clock over twelve; it is off after exit.
// - Hold reset until supply above threshold, then wait the power-on delay.
// - Power-on or monitor reset exit sets the power-on flag, bit 1.
// - Every other reset clears the power-on flag.
// - Only power-on enables the monitor; other resets keep its enable state.
// - Supply below threshold with the monitor enabled and selected drives pin low and holds core until it recovers.
// - Monitor enable only powers it; resets need it selected as source too.
// - A monitor reset release skips the power-on delay.
// - Monitor control bit 6 reads the live supply comparator output.
// - Monitor control bits 5 to 0 are unused, read zero, ignore writes.
// - Reset pin low holds the device in reset; pin flag set on exit unless a power-on or monitor reset was also active.
// - Writing one to the power-on flag selects the monitor as reset source.
module rssm_reset_sequencer
  import rssm_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = RSSM_POR_DELAY_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Supply comparator and reset pin.
  input  wire logic        i_supply_above,
  input  wire logic        i_rst_pin_n,
  output logic             o_rst_pin_out,
  output logic             o_rst_pin_oe,
  // Core controls.
  output logic             o_core_hold,
  output logic             o_sfr_load_defaults,
  output logic             o_irq_timers_disable,
  output logic             o_stack_ptr_reinit,
  output logic             o_data_mem_clear,
  output logic      [7:0]  o_port_latch,
  output logic             o_port_open_drain,
  output logic             o_weak_pullup_en,
  output logic      [15:0] o_pc_load,
  output logic      [1:0]  o_clk_select,
  output logic             o_wdog_enable,
  output logic      [3:0]  o_wdog_divide,
  output logic             o_monitor_power,
  // Interrupt.
  output logic             o_irq
);

  typedef struct packed {
    rssm_state_e state;
    logic [31:0] count;
    logic        por_cause;
    logic        pin_cause;
    logic        mon_enable;
    logic        mon_select;
    logic        power_on_flag;
    logic        pin_flag;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_drive;
    logic        hold;
    logic        irq;
  } rssm_regs_s;

  rssm_regs_s r;
  rssm_regs_s next_r;

  logic access;
  logic wr;
  logic mon_reset_req;
  logic [7:0] ctrl_view;
  logic [7:0] cause_view;

  // Bus decode helpers and the monitor reset request.
  assign access        = i_psel && i_penable && !r.pready;
  assign wr            = i_psel && i_penable && r.pready && i_pwrite;
  assign mon_reset_req = r.mon_enable && r.mon_select && !i_supply_above;
  assign ctrl_view     = {r.mon_enable, i_supply_above, 6'h00};
  assign cause_view    = {6'h00, r.power_on_flag, r.pin_flag};

  // Next-state logic for the sequencer, registers and bus.
  always_comb begin
    next_r         = r;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    case (r.state)
      // Supply still below the threshold: keep the monitor powered and the counter at zero.
      RSSM_ST_POWER_UP: begin
        next_r.por_cause  = 1'b1;
        next_r.mon_enable = 1'b1;
        next_r.count      = 32'h0;
        if (i_supply_above) begin
          next_r.state = RSSM_ST_POR_WAIT;
        end
      end
      // Supply is good: count out the power-on release delay, restart on a dip.
      RSSM_ST_POR_WAIT: begin
        if (!i_supply_above) begin
          next_r.state = RSSM_ST_POWER_UP;
        end else if (r.count >= 32'(POR_DELAY_CYCLES - 1)) begin
          next_r.state = RSSM_ST_IN_RESET;
        end else begin
          next_r.count = r.count + 32'h1;
        end
      end
      // Held in reset until every active source lets go.
      RSSM_ST_IN_RESET: begin
        if (mon_reset_req) begin
          next_r.por_cause = 1'b1;
        end
        if (!i_rst_pin_n && !r.pin_drive) begin
          next_r.pin_cause = 1'b1;
        end
        if (!mon_reset_req && (i_rst_pin_n || r.pin_drive)) begin
          // Exit: monitor release skips the power-on delay.
          next_r.state         = RSSM_ST_RUN;
          next_r.power_on_flag = r.por_cause;
          next_r.pin_flag      = r.pin_cause && !r.por_cause;
          next_r.mon_select    = r.por_cause ? 1'b0 : r.mon_select;
          next_r.irq_status[RSSM_IRQ_BIT_RESET_EXIT] = 1'b1;
        end
      end
      // Running: the monitor request has priority over the pin.
      default: begin
        if (mon_reset_req) begin
          next_r.state     = RSSM_ST_IN_RESET;
          next_r.por_cause = 1'b1;
          next_r.pin_cause = 1'b0;
          next_r.irq_status[RSSM_IRQ_BIT_SUPPLY_LOW] = 1'b1;
        end else if (!i_rst_pin_n) begin
          next_r.state     = RSSM_ST_IN_RESET;
          next_r.por_cause = 1'b0;
          next_r.pin_cause = 1'b1;
        end
      end
    endcase
    next_r.pin_drive = (next_r.state != RSSM_ST_RUN) && next_r.por_cause;
    next_r.hold      = (next_r.state != RSSM_ST_RUN);

    // APB read side: one wait state, then pready with the data and the error flag.
    // The read view is captured when the request is taken, before any write lands.
    if (access) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0;
      if (i_paddr == RSSM_ADDR_MONITOR_CTRL) begin
        next_r.prdata = {24'h0, ctrl_view};
      end else if (i_paddr == RSSM_ADDR_RESET_CAUSE) begin
        next_r.prdata = {24'h0, cause_view};
      end else if (i_paddr == RSSM_ADDR_IRQ_STATUS) begin
        next_r.prdata = {30'h0, r.irq_status};
      end else if (i_paddr == RSSM_ADDR_IRQ_ENABLE) begin
        next_r.prdata = {30'h0, r.irq_enable};
      end else if (i_paddr == RSSM_ADDR_IRQ_CLEAR) begin
        next_r.prdata = 32'h0; // Write-only register reads zero.
      end else begin
        next_r.pslverr = 1'b1;
      end
    end

    // APB write side: lands at the edge where the master samples pready high.
    // Unmapped writes were flagged with pslverr and change nothing here.
    if (wr) begin
      if (i_paddr == RSSM_ADDR_MONITOR_CTRL) begin
        next_r.mon_enable = i_pwdata[RSSM_BIT_MON_ENABLE];
      end else if (i_paddr == RSSM_ADDR_RESET_CAUSE) begin
        if (i_pwdata[RSSM_BIT_POWER_ON]) begin
          next_r.mon_select = 1'b1;
        end
      end else if (i_paddr == RSSM_ADDR_IRQ_ENABLE) begin
        next_r.irq_enable = i_pwdata[1:0];
      end else if (i_paddr == RSSM_ADDR_IRQ_CLEAR) begin
        // Set wins over clear only for bits not already set; a pending bit is cleared even with a new event.
        next_r.irq_status = (r.irq_status & ~i_pwdata[1:0]) | (next_r.irq_status & ~r.irq_status);
      end
    end
    next_r.irq = |(next_r.irq_status & next_r.irq_enable);
  end

  // State register with clock enable.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Power-on reset: pin driven and monitor powered from the first moment.
      r            <= '0;
      r.state      <= RSSM_ST_POWER_UP;
      r.hold       <= 1'b1;
      r.por_cause  <= 1'b1;
      r.pin_drive  <= 1'b1;
      r.mon_enable <= 1'b1;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // Output assignments taken straight from state flip-flops or tied to constants.
  assign o_prdata             = r.prdata;
  assign o_pready             = r.pready;
  assign o_pslverr            = r.pslverr;
  assign o_rst_pin_out        = 1'b0;
  assign o_rst_pin_oe         = r.pin_drive;
  assign o_core_hold          = r.hold;
  assign o_sfr_load_defaults  = r.hold;
  assign o_irq_timers_disable = r.hold;
  assign o_stack_ptr_reinit   = r.hold;
  assign o_data_mem_clear     = 1'b0;
  assign o_port_latch         = RSSM_PORT_LATCH_RESET;
  assign o_port_open_drain    = r.hold;
  assign o_weak_pullup_en     = 1'b1;
  assign o_pc_load            = RSSM_PC_RESET;
  assign o_clk_select         = RSSM_CLKSEL_INTERNAL;
  assign o_wdog_enable        = r.hold;
  assign o_wdog_divide        = RSSM_WDOG_DIVIDE;
  assign o_monitor_power      = r.mon_enable;
  assign o_irq                = r.irq;

  // Checks.
  a_pin_drive_por: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (r.state == RSSM_ST_POWER_UP) |-> r.pin_drive) else $error("pin not driven in power-up");
  a_hold_in_reset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (r.state != RSSM_ST_RUN) |-> o_core_hold) else $error("core not held in reset");
  a_por_delay_min: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && $rose(r.state == RSSM_ST_POR_WAIT) |-> r.count == 32'h0) else $error("delay not restarted");
  a_exit_por_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_IN_RESET && next_r.state == RSSM_ST_RUN |=> r.power_on_flag == $past(r.por_cause))
    else $error("power-on flag wrong at exit");
  a_mon_enable_por: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_POWER_UP |=> r.mon_enable) else $error("monitor not enabled");
  a_mon_reset_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_RUN && mon_reset_req |=> r.state == RSSM_ST_IN_RESET && o_rst_pin_oe)
    else $error("monitor reset missed");
  a_no_unselected: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_RUN && !r.mon_select && i_rst_pin_n |=> r.state == RSSM_ST_RUN)
    else $error("reset without selection");
  a_status_live: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ctrl_view[RSSM_BIT_MON_STATUS] == i_supply_above && ctrl_view[5:0] == 6'h00)
    else $error("status view wrong");
  a_pin_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_RUN && !mon_reset_req && !i_rst_pin_n |=> r.state == RSSM_ST_IN_RESET)
    else $error("pin reset missed");
  a_flags_stable: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    r.state == RSSM_ST_RUN && !wr ##1 r.state == RSSM_ST_RUN |-> $stable(r.pin_flag))
    else $error("flag changed outside exit");

  // Multi-step monitor behaviour is described by these two sequences.
  // Supply drops while the monitor is powered and selected as a source.
  sequence s_mon_trip;
    i_ce && r.state == RSSM_ST_RUN && mon_reset_req;
  endsequence
  // Every source has let go while a power-on type reset is held.
  sequence s_mon_recover;
    i_ce && r.state == RSSM_ST_IN_RESET && r.por_cause && !mon_reset_req && (i_rst_pin_n || r.pin_drive);
  endsequence

  // A monitor release reaches run at the next edge, with no delay count.
  a_mon_release_fast: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_mon_recover |=> r.state == RSSM_ST_RUN && !o_core_hold)
    else $error("monitor release delayed");
  // A monitor trip followed by recovery leaves the power-on flag set.
  a_mon_trip_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_mon_trip ##1 s_mon_recover |=> r.power_on_flag)
    else $error("power-on flag not set after monitor reset");
  // The trip event is recorded even if a clear arrives in the same cycle, provided that status bit was not already pending.
  a_trip_irq_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_mon_trip |=> r.irq_status[RSSM_IRQ_BIT_SUPPLY_LOW])
    else $error("monitor event lost");
  // A pin-only reset exits with the pin flag set and the power-on flag clear.
  a_pin_exit_flags: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_IN_RESET && !r.por_cause && i_rst_pin_n && !mon_reset_req
    |=> r.pin_flag && !r.power_on_flag)
    else $error("pin reset flags wrong");
  // The device stays in reset while an external party holds the pin low.
  a_pin_hold_reset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_IN_RESET && !i_rst_pin_n && !r.pin_drive |=> r.state == RSSM_ST_IN_RESET)
    else $error("left reset with pin low");
  // Outside power-up only software may change the monitor enable.
  a_mon_enable_kept: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state != RSSM_ST_POWER_UP && !wr |=> r.mon_enable == $past(r.mon_enable))
    else $error("monitor enable changed by reset");
  // Writing one to the power-on flag selects the monitor.
  a_select_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && wr && i_paddr == RSSM_ADDR_RESET_CAUSE && i_pwdata[RSSM_BIT_POWER_ON] |=> r.mon_select)
    else $error("monitor not selected");
  // In run the pin is released and the core is free.
  a_run_released: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    r.state == RSSM_ST_RUN |-> !o_rst_pin_oe && !o_core_hold)
    else $error("pin or core held in run");
  // A pin-only reset never drives the pin.
  a_pin_no_drive: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    r.state == RSSM_ST_IN_RESET && !r.por_cause |-> !o_rst_pin_oe)
    else $error("pin driven in pin reset");
  // The delay counter never passes its end point.
  a_por_count_max: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    r.state == RSSM_ST_POR_WAIT |-> r.count < 32'(POR_DELAY_CYCLES))
    else $error("delay counter overran");
  // Reset exit shows the program counter and clock defaults.
  a_exit_defaults: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && r.state == RSSM_ST_IN_RESET ##1 r.state == RSSM_ST_RUN
    |-> o_pc_load == RSSM_PC_RESET && o_clk_select == RSSM_CLKSEL_INTERNAL)
    else $error("exit defaults wrong");
  // While held, the watchdog is enabled with its fixed divider.
  a_wdog_reset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_core_hold |-> o_wdog_enable && o_wdog_divide == RSSM_WDOG_DIVIDE)
    else $error("watchdog defaults wrong");
  // While held, port latches are all ones, open-drain, with pullups.
  a_ports_reset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_core_hold |-> o_port_latch == RSSM_PORT_LATCH_RESET && o_port_open_drain && o_weak_pullup_en)
    else $error("port state wrong in reset");
  // While held, the stack pointer is reloaded but data memory is kept.
  a_mem_kept: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_core_hold |-> o_stack_ptr_reinit && !o_data_mem_clear)
    else $error("memory handling wrong in reset");
  // The bus answer stands for exactly one cycle.
  a_pready_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  // The interrupt line follows enabled status bits.
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_irq == |(r.irq_status & r.irq_enable))
    else $error("interrupt level wrong");

endmodule : rssm_reset_sequencer
